/* sensor_out_pkg.sv */
package sensor_out_pkg;

    // ------------------------------------------------------------
    // Register map (16-bit offsets, 16-bit data)
    // ------------------------------------------------------------
    localparam logic [15:0] SYSTEM_CONTROL_ADDR = 16'h001A;
    localparam logic [15:0] COMMAND_ADDR        = 16'h0080;
    localparam logic [15:0] REQ_STATE_ADDR      = 16'h0082;
    localparam logic [15:0] PRESENT_STATE_ADDR  = 16'h0084;
    localparam logic [15:0] OUT_CFG_ADDR        = 16'h0086;
    localparam logic [15:0] HBLANK_ADDR         = 16'h0088;
    localparam logic [15:0] VBLANK_ADDR         = 16'h008A;
    localparam logic [15:0] WIDTH_ADDR          = 16'h008C;
    localparam logic [15:0] HEIGHT_ADDR         = 16'h008E;
    localparam logic [15:0] INTEG_ADDR          = 16'h0090;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SOFT_RST_BIT  = 0;
    localparam int CMD_SET_BIT   = 1;
    localparam int CMD_OK_BIT    = 15;
    localparam int CFG_SERIAL_BIT = 0;
    localparam int CFG_GATE_BIT  = 1;
    localparam int CFG_PHASE_BIT = 2;
    localparam int CFG_EOF_BIT   = 4;

    // ------------------------------------------------------------
    // System state codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  STATE_STANDBY_REQ = 8'h50;
    localparam logic [7:0]  STATE_STANDBY     = 8'h52;
    localparam logic [7:0]  STATE_STREAM_REQ  = 8'h54;
    localparam logic [7:0]  STATE_STREAMING   = 8'h31;
    localparam logic [15:0] CFG_RST           = 16'h0000;
    localparam logic [15:0] HBLANK_RST        = 16'h0010;
    localparam logic [15:0] VBLANK_RST        = 16'h0004;
    localparam logic [15:0] WIDTH_RST         = 16'h0008;
    localparam logic [15:0] HEIGHT_RST        = 16'h0006;
    localparam logic [15:0] INTEG_RST         = 16'h0010;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 50;
    localparam int BOOT_TIME_NS    = 44_500_000;
    localparam int WAKEUP_TIME_NS  = 1_000_000;
    localparam int LOCK_TIME_NS    = 100_000;
    localparam int LOCK_CYCLES     = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CMD_CYCLES      = 10;
    localparam int OVERHEAD_CYCLES = 16;

    // ------------------------------------------------------------
    // Serial lane
    // ------------------------------------------------------------
    localparam logic [7:0] FS_CODE = 8'h00;
    localparam logic [7:0] FE_CODE = 8'h01;

    typedef enum logic [5:0] {
        L_ULPS = 6'b000001,
        L_LOCK = 6'b000010,
        L_EXIT = 6'b000100,
        L_STOP = 6'b001000,
        L_RUN  = 6'b010000,
        L_EOF  = 6'b100000
    } lane_state_e;

endpackage : sensor_out_pkg

/* sensor_state_and_video_output.sv */
`timescale 1ns/100ps
// Behaviour
// RULE_01: Writing 1 to system_control bit 0 resets the device like the reset pin.
// RULE_02: Host writes 0 to that bit again to resume normal operation.
// RULE_03: Host waits the boot time, then polls the command word until ready.
// RULE_04: Standby request: requested state 0x50, then command word 0x8002.
// RULE_05: Host may check the set-state bit is clear before a new command.
// RULE_06: Device clears the set-state bit when done; host polls with timeout.
// RULE_07: Success bit stays 1 only when the state change succeeded.
// RULE_08: Present state reads 0x52 once standby is fully entered.
// RULE_09: Host stops the clock only after 100 cycles in standby.
// RULE_10: Exit standby: restart clock, wait 100 cycles, request 0x54, command 0x8002.
// RULE_11: After a successful exit the present state reads 0x31, streaming.
// RULE_12: Only one of the parallel port or the serial lane is active.
// RULE_13: Output buffer keeps the pixel clock constant despite varying pixel rate.
// RULE_14: While line valid is high, one pixel per two pixel clock periods.
// RULE_15: Pixel clock runs during blanking unless the gating option is set.
// RULE_16: Pixel clock phase shiftable by half a period; blanking is programmable.
// RULE_17: In standby the clock and data lanes sit in LP-00.
// RULE_18: On streaming entry, after PLL lock and bias settle, lanes go LP-10.
// RULE_19: After the wakeup delay lanes go LP-11; frames follow after integration.
// RULE_20: Frames are high-speed packets with stop state between them.
// RULE_21: Reset abandons any frame at once and returns lanes to LP-00.
// RULE_22: Stop finishes frame if bit 4 set, else finishes packet and sends frame end.
module sensor_state_and_video_output
    import sensor_out_pkg::*;
#(
    parameter int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int WAKE_CYCLES = (WAKEUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int FIFO_DEPTH  = 4
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             pixel_clock_out_o,
    output logic             line_valid_out_o,
    output logic             frame_valid_out_o,
    output logic      [7:0]  pixel_data_o,
    output logic             par_oe_n_o,
    output logic             clk_lane_p_o,
    output logic             clk_lane_n_o,
    output logic             data_lane_p_o,
    output logic             data_lane_n_o,
    output logic             lane_hs_o,
    output logic      [7:0]  lane_byte_o
);

    localparam int PW = $clog2(FIFO_DEPTH);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] system_control, out_cfg, hblank, vblank, line_width, frame_height, integ;
    logic [7:0]  requested_system_state, present_system_state;
    logic        cmd_set_state, cmd_ok, stream_on;
    logic [23:0] boot_cnt;
    logic [7:0]  cmd_cnt;
    lane_state_e lane_st;

    wire soft_rst   = system_control[SOFT_RST_BIT];
    wire booting    = boot_cnt != 24'h000000;
    wire wr_sys     = reg_wr_i && reg_addr_i == SYSTEM_CONTROL_ADDR;
    wire wr_cmd     = reg_wr_i && reg_addr_i == COMMAND_ADDR;
    wire wr_req     = reg_wr_i && reg_addr_i == REQ_STATE_ADDR;
    wire serial_sel = out_cfg[CFG_SERIAL_BIT];

    // Config registers; soft reset reloads all but its own trigger with their reset values
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            system_control         <= 16'h0000;
            out_cfg                <= CFG_RST;
            hblank                 <= HBLANK_RST;
            vblank                 <= VBLANK_RST;
            line_width             <= WIDTH_RST;
            frame_height           <= HEIGHT_RST;
            integ                  <= INTEG_RST;
            requested_system_state <= 8'h00;
        end else begin
            if (wr_sys) system_control <= reg_wdata_i;                    // RULE_01
            if (soft_rst) begin                                          // RULE_01
                out_cfg                <= CFG_RST;
                hblank                 <= HBLANK_RST;
                vblank                 <= VBLANK_RST;
                line_width             <= WIDTH_RST;
                frame_height           <= HEIGHT_RST;
                integ                  <= INTEG_RST;
                requested_system_state <= 8'h00;
            end else if (reg_wr_i) begin
                if (reg_addr_i == OUT_CFG_ADDR) out_cfg <= reg_wdata_i;
                if (reg_addr_i == HBLANK_ADDR) hblank <= reg_wdata_i;   // RULE_16
                if (reg_addr_i == VBLANK_ADDR) vblank <= reg_wdata_i;   // RULE_16
                if (reg_addr_i == WIDTH_ADDR) line_width <= reg_wdata_i;
                if (reg_addr_i == HEIGHT_ADDR) frame_height <= reg_wdata_i;
                if (reg_addr_i == INTEG_ADDR) integ <= reg_wdata_i;
                if (wr_req) requested_system_state <= reg_wdata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Boot timer and set-state command engine
    // ------------------------------------------------------------
    wire cmd_done   = cmd_set_state && !booting && cmd_cnt == 8'h01;
    wire req_valid  = requested_system_state == STATE_STANDBY_REQ
                   || requested_system_state == STATE_STREAM_REQ;
    wire cmd_rd_set = cmd_set_state || booting;

    // Host write in the completion cycle wins over the device clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_cnt      <= 24'(BOOT_CYCLES);
            cmd_set_state <= 1'b0;
            cmd_ok        <= 1'b0;
            cmd_cnt       <= 8'h00;
            stream_on     <= 1'b0;
        end else if (soft_rst) begin
            boot_cnt      <= 24'(BOOT_CYCLES);                           // RULE_01
            cmd_set_state <= 1'b0;
            cmd_ok        <= 1'b0;
            cmd_cnt       <= 8'h00;
            stream_on     <= 1'b0;
        end else begin
            if (booting) boot_cnt <= boot_cnt - 24'h000001;
            if (boot_cnt == 24'h000001) stream_on <= 1'b1;
            if (wr_cmd) begin
                cmd_set_state <= reg_wdata_i[CMD_SET_BIT];
                cmd_ok        <= reg_wdata_i[CMD_OK_BIT];
                cmd_cnt       <= 8'(CMD_CYCLES);
            end else begin
                if (cmd_cnt > 8'h01) cmd_cnt <= cmd_cnt - 8'h01;
                if (cmd_done) begin
                    cmd_set_state <= 1'b0;                               // RULE_06
                    cmd_ok        <= cmd_ok && req_valid;                // RULE_07
                    cmd_cnt       <= 8'h00;
                    if (req_valid) stream_on <= requested_system_state == STATE_STREAM_REQ;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Frame timing in byte slots (two bytes per pixel)
    // ------------------------------------------------------------
    logic        tick;
    logic [16:0] hcnt;
    logic [15:0] vcnt;
    logic        frm_open;
    logic [2:0]  eof_cnt;

    wire [16:0] two_w    = {line_width, 1'b0};
    wire [16:0] line_len = two_w + {1'b0, hblank};
    wire [15:0] frm_last = frame_height + vblank - 16'h0001;
    wire        running  = lane_st == L_RUN;
    wire        line_act = vcnt < frame_height;
    wire        byte_act = running && line_act && hcnt < two_w;
    // Short packets live in blanking; needs hblank >= 4 and vblank >= 1
    wire        fs_win   = running && vcnt == frm_last && hcnt >= two_w && hcnt < two_w + 17'd4;
    wire        fe_win   = running && vcnt == frame_height && hcnt < 17'd4;
    wire        pkt_busy = byte_act || fs_win || fe_win;
    wire [16:0] sp_idx   = fs_win ? hcnt - two_w : hcnt;
    wire        fs_last  = tick && fs_win && sp_idx == 17'd3;
    wire        fe_last  = tick && fe_win && sp_idx == 17'd3;
    wire        eof_mode = out_cfg[CFG_EOF_BIT];

    // Byte slot advance; first slot is the line carrying frame start
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick <= 1'b0;
            hcnt <= 17'h00000;
            vcnt <= 16'h0000;
        end else if (!running) begin
            tick <= 1'b0;
            hcnt <= 17'h00000;
            vcnt <= frm_last;
        end else begin
            tick <= !tick;
            if (tick) begin
                hcnt <= (hcnt == line_len - 17'd1) ? 17'h00000 : hcnt + 17'd1;
                if (hcnt == line_len - 17'd1) vcnt <= (vcnt == frm_last) ? 16'h0000 : vcnt + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Pixel buffer between pixel source and output timing
    // ------------------------------------------------------------
    logic [15:0] fifo_mem [FIFO_DEPTH];
    logic [PW:0] wr_ptr, rd_ptr;
    logic [15:0] pix_src;
    logic [7:0]  pix_lo;

    wire fifo_empty = wr_ptr == rd_ptr;
    wire fifo_full  = wr_ptr == {~rd_ptr[PW], rd_ptr[PW-1:0]};
    wire fifo_push  = running && !fifo_full;
    wire fifo_pop   = tick && byte_act && !hcnt[0] && !fifo_empty;
    wire [15:0] fifo_head = fifo_mem[rd_ptr[PW-1:0]];

    // Producer free-runs ahead; the drain side paces at a fixed slot rate
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            pix_src <= 16'h0000;
            pix_lo  <= 8'h00;
        end else if (!running) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (fifo_push) begin                                         // RULE_13
                fifo_mem[wr_ptr[PW-1:0]] <= pix_src;
                wr_ptr                   <= wr_ptr + 1'b1;
                pix_src                  <= pix_src + 16'h0001;
            end
            if (fifo_pop) begin                                          // RULE_13
                rd_ptr <= rd_ptr + 1'b1;
                pix_lo <= fifo_head[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Lane power sequencing
    // ------------------------------------------------------------
    logic [23:0] lane_cnt;

    wire stop_ok = !pkt_busy && !(eof_mode && frm_open);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_st  <= L_ULPS;
            lane_cnt <= 24'h000000;
            frm_open <= 1'b0;
            eof_cnt  <= 3'h0;
        end else if (soft_rst) begin
            lane_st  <= L_ULPS;                                          // RULE_21
            frm_open <= 1'b0;
        end else begin
            if (lane_cnt != 24'h000000) lane_cnt <= lane_cnt - 24'h000001;
            if (fs_last) frm_open <= 1'b1;
            if (fe_last) frm_open <= 1'b0;
            case (lane_st)
                L_ULPS: if (stream_on) begin                             // RULE_17
                    lane_st  <= L_LOCK;
                    lane_cnt <= 24'(LOCK_CYCLES);
                end
                L_LOCK: if (!stream_on) lane_st <= L_ULPS;
                    else if (lane_cnt == 24'h000000) begin               // RULE_18
                        lane_st  <= L_EXIT;
                        lane_cnt <= 24'(WAKE_CYCLES);
                    end
                L_EXIT: if (!stream_on) lane_st <= L_ULPS;
                    else if (lane_cnt == 24'h000000) begin               // RULE_19
                        lane_st  <= L_STOP;
                        lane_cnt <= {8'h00, integ} + 24'(OVERHEAD_CYCLES);
                    end
                L_STOP: if (!stream_on) lane_st <= L_ULPS;
                    else if (lane_cnt == 24'h000000) lane_st <= L_RUN;   // RULE_19
                L_RUN: if (!stream_on && stop_ok) begin                  // RULE_22
                    lane_st <= frm_open ? L_EOF : L_ULPS;
                    eof_cnt <= 3'h0;
                end
                L_EOF: begin
                    eof_cnt <= eof_cnt + 3'h1;
                    if (eof_cnt == 3'h7) begin                           // RULE_22
                        lane_st  <= L_ULPS;
                        frm_open <= 1'b0;
                    end
                end
                default: lane_st <= L_ULPS;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    // Short packet ECC/checksum not modelled: trailing bytes are zero
    wire [7:0] sp_byte   = (sp_idx == 17'd0) ? (fs_win ? FS_CODE : FE_CODE) : 8'h00;
    wire [7:0] eof_byte  = (eof_cnt[2:1] == 2'b00) ? FE_CODE : 8'h00;
    wire [7:0] pix_byte  = hcnt[0] ? pix_lo : (fifo_empty ? 8'h00 : fifo_head[15:8]);
    wire       par_on    = !serial_sel && running && !soft_rst;                // RULE_12
    wire       ser_on    = serial_sel && !soft_rst;                            // RULE_12
    wire       hs_now    = ser_on && ((running && pkt_busy) || lane_st == L_EOF); // RULE_20
    wire       lp_stop   = ser_on && (lane_st == L_STOP || running);           // RULE_20
    wire       lp_exit   = ser_on && lane_st == L_EXIT;                        // RULE_18
    wire [7:0] next_lane_byte = !hs_now ? 8'h00 : lane_st == L_EOF ? eof_byte
                              : byte_act ? pix_byte : sp_byte;
    wire       next_dp   = !hs_now && (lp_stop || lp_exit);                   // RULE_17
    wire       next_dn   = !hs_now && lp_stop;                                // RULE_19
    wire       next_cp   = lp_stop || lp_exit || hs_now;
    wire       next_cn   = lp_stop || hs_now;
    wire       gate_clk  = out_cfg[CFG_GATE_BIT] && !byte_act;                // RULE_15
    wire       next_pclk = par_on && !gate_clk && (tick ^ out_cfg[CFG_PHASE_BIT]); // RULE_16
    wire [15:0] rd_mux   = reg_addr_i == SYSTEM_CONTROL_ADDR ? system_control
                         : reg_addr_i == COMMAND_ADDR ? {cmd_ok, 13'h0000, cmd_rd_set, 1'b0} // RULE_03
                         : reg_addr_i == REQ_STATE_ADDR ? {8'h00, requested_system_state}
                         : reg_addr_i == PRESENT_STATE_ADDR ? {8'h00, present_system_state}
                         : reg_addr_i == OUT_CFG_ADDR ? out_cfg
                         : reg_addr_i == HBLANK_ADDR ? hblank
                         : reg_addr_i == VBLANK_ADDR ? vblank
                         : reg_addr_i == WIDTH_ADDR ? line_width
                         : reg_addr_i == HEIGHT_ADDR ? frame_height
                         : reg_addr_i == INTEG_ADDR ? integ : 16'h0000;
    // Standby is only reported once the lanes rest in LP-00
    wire [7:0] next_present = (stream_on || lane_st != L_ULPS) ? STATE_STREAMING // RULE_11
                            : STATE_STANDBY;                                     // RULE_08

    // All pins registered so no decode glitch reaches the receiver
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o          <= 16'h0000;
            present_system_state <= STATE_STANDBY;
            pixel_clock_out_o    <= 1'b0;
            line_valid_out_o     <= 1'b0;
            frame_valid_out_o    <= 1'b0;
            pixel_data_o         <= 8'h00;
            par_oe_n_o           <= 1'b1;
            lane_hs_o            <= 1'b0;
            lane_byte_o          <= 8'h00;
            data_lane_p_o        <= 1'b0;
            data_lane_n_o        <= 1'b0;
            clk_lane_p_o         <= 1'b0;
            clk_lane_n_o         <= 1'b0;
        end else begin
            reg_rdata_o          <= rd_mux;
            present_system_state <= next_present;
            pixel_clock_out_o    <= next_pclk;                           // RULE_14
            line_valid_out_o     <= par_on && byte_act;                  // RULE_14
            frame_valid_out_o    <= par_on && line_act;
            pixel_data_o         <= (par_on && byte_act) ? pix_byte : 8'h00; // RULE_14
            par_oe_n_o           <= !par_on;
            lane_hs_o            <= hs_now;
            lane_byte_o          <= next_lane_byte;
            data_lane_p_o        <= next_dp;
            data_lane_n_o        <= next_dn;
            clk_lane_p_o         <= next_cp;
            clk_lane_n_o         <= next_cn;
        end
    end

endmodule : sensor_state_and_video_output

/* sensor_out_props.sv */
`timescale 1ns/100ps
module sensor_out_props
    import sensor_out_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        line_valid_out_o,
    input wire logic        frame_valid_out_o,
    input wire logic [7:0]  pixel_data_o,
    input wire logic        par_oe_n_o,
    input wire logic        clk_lane_p_o,
    input wire logic        clk_lane_n_o,
    input wire logic        data_lane_p_o,
    input wire logic        data_lane_n_o,
    input wire logic        lane_hs_o,
    input wire logic [7:0]  lane_byte_o
);
    // ----------------------------------------
    // Lane idle decode
    // ----------------------------------------
    wire lanes_off = !(clk_lane_p_o | clk_lane_n_o | data_lane_p_o | data_lane_n_o | lane_hs_o);
    wire lp10      = data_lane_p_o & !data_lane_n_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_PAR_LANES: assert property (!par_oe_n_o |-> lanes_off)
        else $error("serial lane active while parallel port drives");
    AST_HS_PAR: assert property (lane_hs_o |-> par_oe_n_o && !line_valid_out_o)
        else $error("parallel port active during lane traffic");
    AST_HS_LP: assert property (lane_hs_o |-> !data_lane_p_o && !data_lane_n_o)
        else $error("low power levels during lane byte");
    AST_HS_HOLD: assert property ($rose(lane_hs_o) |=> lane_hs_o && $stable(lane_byte_o))
        else $error("lane byte not held two cycles");
    AST_PIX_BLANK: assert property (!line_valid_out_o |-> pixel_data_o == 8'h00)
        else $error("pixel data outside line valid");
    AST_LV_IN_FV: assert property (line_valid_out_o |-> frame_valid_out_o)
        else $error("line valid outside frame valid");
    AST_SOFT_RST: assert property (reg_wr_i && reg_addr_i == SYSTEM_CONTROL_ADDR && reg_wdata_i[0] |=> ##1 lanes_off)
        else $error("lanes not idle after soft reset");
    AST_STANDBY_LP00: assert property ($past(reg_addr_i) == PRESENT_STATE_ADDR && reg_rdata_o == {8'h00, STATE_STANDBY}
        |-> lanes_off)
        else $error("lanes not in ultra low power during standby");
    AST_WAKE: assert property ($rose(data_lane_p_o) && !data_lane_n_o
        |-> lp10[*8] ##1 lp10 ##1 (data_lane_p_o && data_lane_n_o))
        else $error("wakeup delay not kept before stop state");
endmodule : sensor_out_props

/* lane_receiver_model.sv */
`timescale 1ns/100ps
module lane_receiver_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        lane_hs_i,
    input  wire logic        data_p_i,
    input  wire logic        data_n_i,
    output logic      [15:0] packets_o,
    output logic      [15:0] faults_o
);
    logic hs_q;
    logic stop_q;
    // Packet starts must come out of the stop state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {hs_q, stop_q, packets_o, faults_o} <= '0;
        end else begin
            hs_q   <= lane_hs_i;
            stop_q <= data_p_i & data_n_i;
            if (lane_hs_i && !hs_q) begin
                if (stop_q) packets_o <= packets_o + 16'h0001;
                else faults_o <= faults_o + 16'h0001;
            end
        end
    end
endmodule : lane_receiver_model

/* sensor_state_and_video_output_tb.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module sensor_state_and_video_output_tb
    import sensor_out_pkg::*;
;
    logic core_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, pclk, lv, fv, oe_n, cp, cn, dp, dn, hs;
    logic [15:0] reg_addr_i = '0, reg_wdata_i = '0, rdata, v, packets, faults;
    logic [7:0]  pix, lbyte;
    int          failures = 0, num_checks = 0, cycles = 0;
    // Rows after reset and the OUT_CFG serial-select write: address and expected read
    logic [15:0] row_a[10] = '{COMMAND_ADDR, PRESENT_STATE_ADDR, OUT_CFG_ADDR, HBLANK_ADDR, VBLANK_ADDR,
                               WIDTH_ADDR, HEIGHT_ADDR, INTEG_ADDR, 16'h0002, SYSTEM_CONTROL_ADDR};
    logic [15:0] row_e[10] = '{16'h0002, 16'h0052, 16'h0001, HBLANK_RST, VBLANK_RST,
                               WIDTH_RST, HEIGHT_RST, INTEG_RST, 16'h0000, 16'h0000};
    sensor_state_and_video_output #(.BOOT_CYCLES(20), .WAKE_CYCLES(8)) i_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .pixel_clock_out_o(pclk), .line_valid_out_o(lv),
        .frame_valid_out_o(fv), .pixel_data_o(pix), .par_oe_n_o(oe_n), .clk_lane_p_o(cp), .clk_lane_n_o(cn),
        .data_lane_p_o(dp), .data_lane_n_o(dn), .lane_hs_o(hs), .lane_byte_o(lbyte));
    lane_receiver_model i_rx (.clk_i(core_clk_i), .rst_i(rst_i), .lane_hs_i(hs), .data_p_i(dp),
        .data_n_i(dn), .packets_o(packets), .faults_o(faults));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Hang guard
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 100000) begin
            `CHK("timeout", 1'b0, 1'b1)
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    // Read data lags the address by one edge
    task automatic rd(input logic [15:0] a);
        @(negedge core_clk_i);
        reg_addr_i = a;
        @(negedge core_clk_i);
        v = rdata;
    endtask : rd
    task automatic wait_for(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        int n;
        n = 0;
        rd(a);
        while ((v & m) !== e && n < 3000) begin
            rd(a);
            n++;
        end
        `CHK("poll", e, v & m)
    endtask : wait_for
    task automatic set_state(input logic [7:0] s, input logic ok);
        wr(REQ_STATE_ADDR, {8'h00, s});
        rd(COMMAND_ADDR);
        `CHK("cmd idle", 1'b0, v[CMD_SET_BIT])
        wr(COMMAND_ADDR, 16'h8002);
        wait_for(COMMAND_ADDR, 16'h0002, 16'h0000);
        rd(COMMAND_ADDR);
        `CHK("cmd ok", ok, v[CMD_OK_BIT])
    endtask : set_state
    initial begin
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'b0;
        wr(OUT_CFG_ADDR, 16'h0001);
        wr(PRESENT_STATE_ADDR, 16'hFFFF);
        for (int i = 0; i < 10; i++) begin
            rd(row_a[i]);
            `CHK("reg", row_e[i], v)
        end
        wait_for(COMMAND_ADDR, 16'h0002, 16'h0000);
        wait_for(PRESENT_STATE_ADDR, 16'hFFFF, 16'h0031);
        for (int i = 0; i < 5000 && hs !== 1'b1; i++) @(negedge core_clk_i);
        `CHK("hs", 1'b1, hs)
        `CHK("par_oe_n", 1'b1, oe_n)
        repeat (700) @(negedge core_clk_i);
        `CHK("faults", 16'h0000, faults)
        `CHK("packets", 1'b1, packets > 16'h0001)
        set_state(STATE_STANDBY_REQ, 1'b1);
        wait_for(PRESENT_STATE_ADDR, 16'hFFFF, 16'h0052);
        `CHK("lanes", 5'h00, {cp, cn, dp, dn, hs})
        repeat (100) @(negedge core_clk_i);
        set_state(STATE_STREAM_REQ, 1'b1);
        rd(PRESENT_STATE_ADDR);
        `CHK("present", 16'h0031, v)
        set_state(8'h33, 1'b0);
        for (int i = 0; i < 5000 && hs !== 1'b1; i++) @(negedge core_clk_i);
        wr(SYSTEM_CONTROL_ADDR, 16'h0001);
        repeat (2) @(negedge core_clk_i);
        `CHK("lanes", 5'h00, {cp, cn, dp, dn, hs})
        wr(SYSTEM_CONTROL_ADDR, 16'h0000);
        rd(OUT_CFG_ADDR);
        `CHK("cfg", CFG_RST, v)
        rd(COMMAND_ADDR);
        `CHK("boot", 16'h0002, v)
        for (int i = 0; i < 5000 && lv !== 1'b1; i++) @(negedge core_clk_i);
        `CHK("par", 4'h1, {oe_n, hs, dp, lv})
        v[0] = pclk;
        @(negedge core_clk_i);
        `CHK("pclk", !v[0], pclk)
        end_of_test();
    end
endmodule : sensor_state_and_video_output_tb
bind sensor_state_and_video_output sensor_out_props i_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .line_valid_out_o(line_valid_out_o), .frame_valid_out_o(frame_valid_out_o), .pixel_data_o(pixel_data_o),
    .par_oe_n_o(par_oe_n_o), .clk_lane_p_o(clk_lane_p_o), .clk_lane_n_o(clk_lane_n_o),
    .data_lane_p_o(data_lane_p_o), .data_lane_n_o(data_lane_n_o), .lane_hs_o(lane_hs_o), .lane_byte_o(lane_byte_o));
